//--- common/bir_pkg.sv
// Constants of the board information and reset register bank
package bir_pkg;
    localparam int          REG_AW              = 16;
    localparam int          DATA_W              = 32;
    // Register indexes
    localparam logic [15:0] CMD_PORT_IDX        = 16'h0064;
    localparam logic [15:0] KERNEL_REV_IDX      = 16'h04BA;
    localparam logic [15:0] VARIANT_MOD_IDX     = 16'h0C3A;
    // Command codes
    localparam logic [31:0] FULL_BOARD_RESET_CODE = 32'h0000_0001;
    // Revision word fields
    localparam int          REV_MAJOR_LSB       = 24;
    localparam int          REV_MINOR_LSB       = 16;
    localparam int          REV_BUILD_LSB       = 0;
    // Variant word fields
    localparam int          BASE_VAR_LSB        = 0;
    localparam int          FE_VAR_LSB          = 8;
    localparam int          HUB_VAR_LSB         = 16;
    localparam logic [31:0] BASE_VAR_MASK       = 32'h0000_00FF;
    localparam logic [31:0] FE_VAR_MASK         = 32'h0000_FF00;
    localparam logic [31:0] HUB_VAR_MASK        = 32'h00FF_0000;
    // Length of the commanded board reset pulse in clock cycles
    localparam int          BOARD_RST_CYCLES    = 16;
    localparam logic [4:0]  BOARD_RST_LAST      = 5'h0F;
    localparam logic [31:0] ZERO_WORD           = 32'h0000_0000;
endpackage

//--- src/bir_rst_seq.sv
// Board reset pulse stretcher
`timescale 1ns/1ps
`default_nettype none
module bir_rst_seq (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      board_rst
);
    import bir_pkg::*;
    logic [4:0] cnt;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt       <= 5'h00;
            board_rst <= 1'b0;
        end else if (start) begin
            cnt       <= 5'h00;
            board_rst <= 1'b1;
        end else if (board_rst) begin
            cnt       <= cnt + 5'h01;
            if (cnt == BOARD_RST_LAST) begin
                board_rst <= 1'b0;
            end
        end
    end

    a_pulse_length: assert property (@(posedge clk) disable iff (!rstn)
        $fell(board_rst) |-> $past(cnt) == BOARD_RST_LAST)
        else $error("board reset pulse too short");
endmodule
`default_nettype wire

//--- src/bir_variant_word.sv
// Packs the variant modification word
`timescale 1ns/1ps
`default_nettype none
module bir_variant_word (
    input  wire logic [7:0]  base_code,
    input  wire logic [7:0]  fe_code,
    input  wire logic [7:0]  hub_code,
    output logic      [31:0] word
);
    import bir_pkg::*;
    always_comb begin
        word = ZERO_WORD;
        word[BASE_VAR_LSB +: 8] = base_code;
        word[FE_VAR_LSB +: 8]   = fe_code;
        word[HUB_VAR_LSB +: 8]  = hub_code;
    end
endmodule
`default_nettype wire

//--- src/bir_regs.sv
// Board information registers and commanded board reset
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module bir_regs (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [bir_pkg::REG_AW-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [bir_pkg::DATA_W-1:0] reg_wdata,
    output logic      [bir_pkg::DATA_W-1:0] reg_rdata,
    output logic                        reg_rvalid,
    input  wire logic [7:0]             kernel_major,
    input  wire logic [7:0]             kernel_minor,
    input  wire logic [15:0]            kernel_build,
    input  wire logic [7:0]             base_card_variant_field,
    input  wire logic [7:0]             front_end_variant_field,
    input  wire logic [7:0]             hub_module_variant_field,
    input  wire logic                   mem_write_done,
    input  wire logic                   trig_out_req,
    input  wire logic                   clk_out_req,
    output logic                        board_rst_n,
    output logic                        sample_mem_valid,
    output logic                        trig_out_en,
    output logic                        clk_out_en
);
    import bir_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Decoding
    function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] idx);
        hit = (a == idx);
    endfunction

    logic        board_rst;
    logic        reset_cmd;
    logic [31:0] variant_word;
    logic [31:0] kernel_word;
    logic [31:0] next_rdata;

    // Only a write of the reset code to the command port acts
    assign reset_cmd = reg_wr && hit(reg_addr, CMD_PORT_IDX)
                       && (reg_wdata == FULL_BOARD_RESET_CODE);

    //////////////////////////////////////////////////////////////////////////
    // Reset pulse
    bir_rst_seq u_rst (
        .clk       (clk),
        .rstn      (rstn),
        .start     (reset_cmd),
        .board_rst (board_rst)
    );

    // Same line as power-on reset drives the rest of the board
    assign board_rst_n = rstn && !board_rst;

    //////////////////////////////////////////////////////////////////////////
    // Information words
    bir_variant_word u_var (
        .base_code (base_card_variant_field),
        .fe_code   (front_end_variant_field),
        .hub_code  (hub_module_variant_field),
        .word      (variant_word)
    );

    always_comb begin
        kernel_word = ZERO_WORD;
        kernel_word[REV_MAJOR_LSB +: 8]  = kernel_major;
        kernel_word[REV_MINOR_LSB +: 8]  = kernel_minor;
        kernel_word[REV_BUILD_LSB +: 16] = kernel_build;
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path; command port reads zero, writes elsewhere ignored
    always_comb begin
        next_rdata = ZERO_WORD;
        if (hit(reg_addr, KERNEL_REV_IDX)) begin
            next_rdata = kernel_word;
        end else if (hit(reg_addr, VARIANT_MOD_IDX)) begin
            next_rdata = variant_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata  <= ZERO_WORD;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Memory validity: cleared by any reset, set by a completed write
    always_ff @(posedge clk) begin
        if (!rstn || board_rst || reset_cmd) begin
            sample_mem_valid <= 1'b0;
        end else if (mem_write_done) begin
            sample_mem_valid <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Output enables
    always_ff @(posedge clk) begin
        if (!rstn || board_rst || reset_cmd) begin
            trig_out_en <= 1'b0;
            clk_out_en  <= 1'b0;
        end else begin
            trig_out_en <= trig_out_req;
            clk_out_en  <= clk_out_req;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    a_cmd_starts_rst: assert property (@(posedge clk) disable iff (!rstn)
        reset_cmd |=> board_rst && !board_rst_n)
        else $error("reset code did not start board reset");

    a_rst_holds_long: assert property (@(posedge clk) disable iff (!rstn)
        reset_cmd |=> !board_rst_n [*8])
        else $error("board reset not held");

    a_other_code_idle: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && (reg_wdata != FULL_BOARD_RESET_CODE) && !board_rst |=> board_rst_n)
        else $error("non-reset command caused reset");

    a_mem_invalid: assert property (@(posedge clk) disable iff (!rstn)
        reset_cmd |=> !sample_mem_valid [*2])
        else $error("memory still valid after reset");

    a_outputs_off: assert property (@(posedge clk) disable iff (!rstn)
        board_rst |=> !trig_out_en && !clk_out_en)
        else $error("outputs enabled during reset");

    a_kernel_read: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, KERNEL_REV_IDX) |=>
        reg_rvalid && reg_rdata[31:24] == $past(kernel_major)
        && reg_rdata[15:0] == $past(kernel_build))
        else $error("kernel revision read wrong");

    a_variant_top: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata[31:24] == 8'h00 && reg_rdata[7:0] == $past(base_card_variant_field))
        else $error("variant word wrong");

    a_variant_hub: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata[23:16] == $past(hub_module_variant_field)
        && reg_rdata[15:8] == $past(front_end_variant_field))
        else $error("variant module bytes wrong");

    a_cmd_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, CMD_PORT_IDX) |=> reg_rdata == 32'h0000_0000)
        else $error("command port not write-only");

    //////////////////////////////////////////////////////////////////////////
    // Helper state for the checks
    logic [4:0] rst_run;

    // Length of the current board reset pulse; a new reset code counts afresh
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rst_run <= 5'h00;
        end else if (reset_cmd) begin
            rst_run <= 5'h00;
        end else if (board_rst) begin
            rst_run <= rst_run + 5'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks on pulse length, read path, memory flag and output enables
    a_rst_len: assert property (@(posedge clk) disable iff (!rstn)
        $fell(board_rst) |->
        rst_run == 5'(BOARD_RST_CYCLES))
        else $error("board reset pulse length wrong");

    a_pulse_bounded: assert property (@(posedge clk) disable iff (!rstn)
        board_rst |->
        rst_run < 5'(BOARD_RST_CYCLES))
        else $error("board reset pulse overran");

    a_rst_line_low: assert property (@(posedge clk) disable iff (!rstn)
        board_rst |->
        !board_rst_n)
        else $error("board reset line high during pulse");

    a_rst_pin_free: assert property (@(posedge clk) disable iff (!rstn)
        !board_rst |->
        board_rst_n)
        else $error("board reset line low without pulse");

    a_cmd_restarts: assert property (@(posedge clk) disable iff (!rstn)
        reset_cmd && board_rst |=>
        board_rst && rst_run == 5'h00)
        else $error("reset code during pulse did not restart it");

    a_ro_wr_ignored: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && !hit(reg_addr, CMD_PORT_IDX) && !board_rst |=>
        !board_rst)
        else $error("write to read-only index caused reset");

    a_read_no_rst: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && !reg_wr && !board_rst |=>
        !board_rst)
        else $error("read caused board reset");

    a_rdata_holds: assert property (@(posedge clk) disable iff (!rstn)
        !reg_rd |=>
        $stable(reg_rdata))
        else $error("read data changed without read");

    a_rvalid_follows: assert property (@(posedge clk) disable iff (!rstn)
        reg_rvalid |->
        $past(reg_rd))
        else $error("read valid without read");

    a_rvalid_single: assert property (@(posedge clk) disable iff (!rstn)
        !reg_rd |=>
        !reg_rvalid)
        else $error("read valid held too long");

    a_var_rvalid: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rvalid)
        else $error("variant read not answered");

    a_kernel_minor: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, KERNEL_REV_IDX) |=>
        reg_rdata[REV_MINOR_LSB +: 8] == $past(kernel_minor))
        else $error("kernel minor field wrong");

    a_base_byte: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata[BASE_VAR_LSB +: 8] == $past(base_card_variant_field))
        else $error("base card byte wrong");

    a_front_byte: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata[FE_VAR_LSB +: 8] == $past(front_end_variant_field))
        else $error("front-end byte wrong");

    a_hub_byte: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata[HUB_VAR_LSB +: 8] == $past(hub_module_variant_field))
        else $error("hub module byte wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && !hit(reg_addr, KERNEL_REV_IDX) && !hit(reg_addr, VARIANT_MOD_IDX) |=>
        reg_rdata == ZERO_WORD)
        else $error("unmapped read not zero");

    a_mem_held_off: assert property (@(posedge clk) disable iff (!rstn)
        board_rst |=>
        !sample_mem_valid)
        else $error("memory marked valid during reset");

    a_mem_set: assert property (@(posedge clk) disable iff (!rstn)
        mem_write_done && !board_rst && !reset_cmd |=>
        sample_mem_valid)
        else $error("completed write did not mark memory valid");

    a_mem_keeps: assert property (@(posedge clk) disable iff (!rstn)
        sample_mem_valid && !board_rst && !reset_cmd |=>
        sample_mem_valid)
        else $error("memory valid flag dropped without reset");

    a_cmd_outs_off: assert property (@(posedge clk) disable iff (!rstn)
        reset_cmd |=>
        !trig_out_en && !clk_out_en)
        else $error("outputs still enabled after reset code");

    a_trig_follows: assert property (@(posedge clk) disable iff (!rstn)
        !board_rst && !reset_cmd |=>
        trig_out_en == $past(trig_out_req))
        else $error("trigger output enable did not follow request");

    a_clk_follows: assert property (@(posedge clk) disable iff (!rstn)
        !board_rst && !reset_cmd |=>
        clk_out_en == $past(clk_out_req))
        else $error("clock output enable did not follow request");
endmodule
`default_nettype wire

//--- testbench/board_info_and_reset_regs_tb_top.sv
// Self-checking bench for the board information and reset registers
`timescale 1ns/1ps
`default_nettype none
module board_info_and_reset_regs_tb_top;
    import bir_pkg::*;
    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic [15:0] reg_addr  = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic [7:0]  kmaj      = 8'h01;
    logic [7:0]  kmin      = 8'h0B;
    logic [15:0] kbld      = 16'h0331;
    logic [7:0]  vb        = 8'h5A;
    logic [7:0]  vf        = 8'hC3;
    logic [7:0]  vh        = 8'h7E;
    logic        mem_done  = 1'b0;
    logic        trig_req  = 1'b0;
    logic        clko_req  = 1'b0;
    logic        board_rst_n;
    logic        mem_valid;
    logic        trig_en;
    logic        clko_en;
    int          n_errors  = 0;
    int          num_checks = 0;
    int          low_cnt   = 0;
    int          i;

    always #10 clk = ~clk;

    // Counts cycles with the board reset asserted
    always @(posedge clk) begin
        if (board_rst_n === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end
    end

    bir_regs dut (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .kernel_major(kmaj), .kernel_minor(kmin), .kernel_build(kbld),
        .base_card_variant_field(vb), .front_end_variant_field(vf), .hub_module_variant_field(vh),
        .mem_write_done(mem_done), .trig_out_req(trig_req), .clk_out_req(clko_req),
        .board_rst_n(board_rst_n), .sample_mem_valid(mem_valid), .trig_out_en(trig_en), .clk_out_en(clko_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask

    task automatic cyc();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc();
        reg_wr = 1'b0;
        cyc();
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc();
        reg_rd = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, exp);
        cyc();
        chk({31'h0, reg_rvalid}, 32'h0);
    endtask

    task automatic outs(input logic [3:0] exp);
        chk({28'h0, board_rst_n, mem_valid, trig_en, clko_en}, {28'h0, exp});
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1'b1;
        cyc();
        outs(4'b1000);
        $display("test reset state done");
        rd(KERNEL_REV_IDX, {kmaj, kmin, kbld});
        rd(VARIANT_MOD_IDX, {8'h00, vh, vf, vb});
        vb = 8'hFF;
        vf = 8'h00;
        vh = 8'hFF;
        rd(VARIANT_MOD_IDX, 32'h00FF_00FF);
        $display("test info reads done");
        wr(KERNEL_REV_IDX, 32'hFFFF_FFFF);
        rd(KERNEL_REV_IDX, {kmaj, kmin, kbld});
        wr(VARIANT_MOD_IDX, 32'hFFFF_FFFF);
        rd(VARIANT_MOD_IDX, 32'h00FF_00FF);
        rd(CMD_PORT_IDX, ZERO_WORD);
        rd(16'h0065, ZERO_WORD);
        $display("test read-only and unmapped done");
        trig_req = 1'b1;
        clko_req = 1'b1;
        mem_done = 1'b1;
        cyc();
        mem_done = 1'b0;
        cyc();
        outs(4'b1111);
        low_cnt = 0;
        wr(CMD_PORT_IDX, 32'h0000_0002);
        wr(CMD_PORT_IDX, 32'h0000_0100);
        outs(4'b1111);
        chk(low_cnt, 32'h0);
        wr(CMD_PORT_IDX, FULL_BOARD_RESET_CODE);
        outs(4'b0000);
        for (i = 0; i < 40 && board_rst_n !== 1'b1; i++) begin
            cyc();
        end
        if (board_rst_n !== 1'b1) begin
            n_errors++;
            test_done();
        end
        chk(low_cnt, BOARD_RST_CYCLES);
        repeat (3) cyc();
        outs(4'b1011);
        rd(KERNEL_REV_IDX, {kmaj, kmin, kbld});
        $display("test board command done");
        test_done();
    end
endmodule
`default_nettype wire
